// [inc/flags_pkg.sv]
// package: status flag positions, APB offsets, jump condition selectors for the flags block
// assumes an APB master on a 50 MHz core clock and a CPU execution unit on the same clock
package flags_pkg;
  // bit positions
  localparam int CARRY_BIT = 7;
  localparam int ZERO_BIT = 6;
  localparam int SIGN_BIT = 5;
  localparam int OVERFLOW_BIT = 4;
  localparam int DECIMAL_ADJUST_BIT = 3;
  localparam int HALF_CARRY_BIT = 2;
  localparam int USER_FLAG_2_BIT = 1;
  localparam int USER_FLAG_1_BIT = 0;
  localparam logic [7:0] CONDITION_MASK = 8'hfc;
  localparam logic [7:0] USER_MASK = 8'h03;
  localparam logic [7:0] CONDITION_RESET = 8'h00;
  // apb byte offsets
  localparam logic [11:0] FLAGS_OFFSET = 12'h000;
  localparam logic [11:0] JUMP_TEST_OFFSET = 12'h004;
  localparam logic [11:0] SAVED_OFFSET = 12'h008;
  // jump condition selectors
  typedef enum logic [2:0] {
    COND_NEVER, COND_CARRY, COND_ZERO, COND_SIGN, COND_OVERFLOW,
    COND_ALWAYS, COND_SIGNED_LT, COND_UNSIGNED_LE
  } jump_cond_type;
endpackage

// [inc/flags_update_if.sv]
// interface: flag update requests from the cpu execution unit and apb software loads into the flags register
// assumes the producer and the register run on the same clock
`timescale 1ns/1ps
interface flags_update_if;
  logic alu_valid;
  logic [7:0] alu_mask;
  logic [7:0] alu_value;
  logic user_valid;
  logic [1:0] user_mask;
  logic [1:0] user_value;
  logic restore_valid;
  logic [7:0] restore_value;
  logic load_valid;
  logic [7:0] load_value;
  modport source (output alu_valid, alu_mask, alu_value, user_valid, user_mask, user_value,
    restore_valid, restore_value, load_valid, load_value);
  modport sink (input alu_valid, alu_mask, alu_value, user_valid, user_mask, user_value,
    restore_valid, restore_value, load_valid, load_value);
endinterface

// [design/flags_store.sv]
// flags byte storage with priority between update sources
// assumes at most one cpu source per cycle; restore wins, then software load
`timescale 1ns/1ps
module flags_store (
  input wire logic clk_in,
  input wire logic rst_in,
  flags_update_if.sink upd,
  output logic [7:0] flags_out
);
  logic [7:0] cond_reg;
  logic [7:0] user_reg;

  // condition bits have a defined reset value
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cond_reg <= flags_pkg::CONDITION_RESET;
    end else if (upd.restore_valid) begin
      cond_reg <= upd.restore_value & flags_pkg::CONDITION_MASK;
    end else if (upd.load_valid) begin
      cond_reg <= upd.load_value & flags_pkg::CONDITION_MASK;
    end else if (upd.alu_valid) begin
      // only bits the operation affects change
      cond_reg <= (cond_reg & ~(upd.alu_mask & flags_pkg::CONDITION_MASK))
        | (upd.alu_value & upd.alu_mask & flags_pkg::CONDITION_MASK);
    end
  end

  // user flags: no reset term at all, so reset leaves them untouched
  always_ff @(posedge clk_in) begin
    if (upd.restore_valid) begin
      user_reg <= upd.restore_value & flags_pkg::USER_MASK;
    end else if (upd.load_valid) begin
      user_reg <= upd.load_value & flags_pkg::USER_MASK;
    end else if (upd.user_valid) begin
      user_reg <= (user_reg & ~{6'h00, upd.user_mask}) | {6'h00, upd.user_value & upd.user_mask};
    end
  end

  assign flags_out = cond_reg | user_reg;
endmodule

// [design/cpu_status_flags.sv]
// cpu status flags register with apb view, jump condition test and stack push/pop
// assumes execution unit and apb master share CLK_IN; one request of each kind per cycle
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module cpu_status_flags (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // alu result flags
  input wire logic ALU_VALID_IN,
  input wire logic [7:0] ALU_MASK_IN,
  input wire logic [7:0] ALU_VALUE_IN,
  // explicit user flag instructions
  input wire logic USER_VALID_IN,
  input wire logic [1:0] USER_MASK_IN,
  input wire logic [1:0] USER_VALUE_IN,
  // stack save and restore
  input wire logic SAVE_REQ_IN,
  input wire logic RESTORE_REQ_IN,
  input wire logic [7:0] RESTORE_DATA_IN,
  output logic PUSH_VALID_OUT,
  output logic [7:0] PUSH_DATA_OUT,
  // conditional jump test
  input wire logic [2:0] JUMP_COND_IN,
  input wire logic JUMP_INVERT_IN,
  output logic JUMP_TAKEN_OUT,
  // flags view
  output logic [7:0] FLAGS_OUT
);
  flags_update_if upd ();
  logic [7:0] flags;
  logic [7:0] saved_reg;
  logic [2:0] sw_cond_reg;
  logic sw_invert_reg;
  logic apb_access;
  logic apb_write;
  logic addr_ok;

  // jump condition from the four testable flags only
  function automatic logic eval_cond(input logic [7:0] f, input logic [2:0] sel,
                                     input logic inv);
    logic c;
    c = 1'b0;
    unique case (flags_pkg::jump_cond_type'(sel))
      flags_pkg::COND_NEVER: c = 1'b0;
      flags_pkg::COND_CARRY: c = f[flags_pkg::CARRY_BIT];
      flags_pkg::COND_ZERO: c = f[flags_pkg::ZERO_BIT];
      flags_pkg::COND_SIGN: c = f[flags_pkg::SIGN_BIT];
      flags_pkg::COND_OVERFLOW: c = f[flags_pkg::OVERFLOW_BIT];
      flags_pkg::COND_ALWAYS: c = 1'b1;
      flags_pkg::COND_SIGNED_LT: c = f[flags_pkg::SIGN_BIT] ^ f[flags_pkg::OVERFLOW_BIT];
      flags_pkg::COND_UNSIGNED_LE: c = f[flags_pkg::CARRY_BIT] | f[flags_pkg::ZERO_BIT];
    endcase
    return c ^ inv;
  endfunction

  assign apb_access = PSEL_IN & PENABLE_IN;
  assign apb_write = apb_access & PWRITE_IN & addr_ok;
  assign addr_ok = (PADDR_IN == flags_pkg::FLAGS_OFFSET)
    | (PADDR_IN == flags_pkg::JUMP_TEST_OFFSET)
    | (PADDR_IN == flags_pkg::SAVED_OFFSET);

  assign upd.alu_valid = ALU_VALID_IN;
  assign upd.alu_mask = ALU_MASK_IN;
  assign upd.alu_value = ALU_VALUE_IN;
  assign upd.user_valid = USER_VALID_IN;
  assign upd.user_mask = USER_MASK_IN;
  assign upd.user_value = USER_VALUE_IN;
  assign upd.restore_valid = RESTORE_REQ_IN;
  assign upd.restore_value = RESTORE_DATA_IN;
  assign upd.load_valid = apb_write & (PADDR_IN == flags_pkg::FLAGS_OFFSET) & PSTRB_IN[0];
  assign upd.load_value = PWDATA_IN[7:0];

  flags_store store (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .upd(upd),
    .flags_out(flags)
  );

  // push the whole byte, user flags included
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      PUSH_VALID_OUT <= 1'b0;
      PUSH_DATA_OUT <= 8'h00;
    end else begin
      PUSH_VALID_OUT <= SAVE_REQ_IN;
      if (SAVE_REQ_IN) begin
        PUSH_DATA_OUT <= flags;
      end
    end
  end

  // last pushed byte, visible to software
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      saved_reg <= 8'h00;
    end else if (SAVE_REQ_IN) begin
      saved_reg <= flags;
    end
  end

  // registered jump decision and flags view
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      JUMP_TAKEN_OUT <= 1'b0;
      FLAGS_OUT <= 8'h00;
    end else begin
      JUMP_TAKEN_OUT <= eval_cond(flags, JUMP_COND_IN, JUMP_INVERT_IN);
      FLAGS_OUT <= flags;
    end
  end

  // software jump test selector
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      sw_cond_reg <= 3'h0;
      sw_invert_reg <= 1'b0;
    end else if (apb_write & (PADDR_IN == flags_pkg::JUMP_TEST_OFFSET) & PSTRB_IN[0]) begin
      sw_cond_reg <= PWDATA_IN[2:0];
      sw_invert_reg <= PWDATA_IN[3];
    end
  end

  // apb: one wait state, ready pulses in the second access cycle
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
    end else if (apb_access & ~PREADY_OUT) begin
      PREADY_OUT <= 1'b1;
      PSLVERR_OUT <= ~addr_ok;
      PRDATA_OUT <= 32'h00000000;
      if (~PWRITE_IN) begin
        unique case (1'b1)
          PADDR_IN == flags_pkg::FLAGS_OFFSET: PRDATA_OUT <= {24'h000000, flags};
          PADDR_IN == flags_pkg::JUMP_TEST_OFFSET:
            PRDATA_OUT <= {27'h0000000, eval_cond(flags, sw_cond_reg, sw_invert_reg),
                           sw_invert_reg, sw_cond_reg};
          PADDR_IN == flags_pkg::SAVED_OFFSET: PRDATA_OUT <= {24'h000000, saved_reg};
          default: PRDATA_OUT <= 32'h00000000;
        endcase
      end
    end else begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end
  end
endmodule

// [testbench/cpu_status_flags_asserts.sv]
// checker: port-level timing of the flags block
// assumes bound to cpu_status_flags, one clock
`timescale 1ns/1ps
module cpu_status_flags_asserts (
  input wire logic CLK_IN, input wire logic SYS_RST_IN,
  input wire logic PSEL_IN, input wire logic PENABLE_IN,
  input wire logic [11:0] PADDR_IN, input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT, input wire logic ALU_VALID_IN,
  input wire logic [7:0] ALU_MASK_IN, input wire logic [7:0] ALU_VALUE_IN,
  input wire logic USER_VALID_IN, input wire logic SAVE_REQ_IN,
  input wire logic RESTORE_REQ_IN, input wire logic [7:0] RESTORE_DATA_IN,
  input wire logic PUSH_VALID_OUT, input wire logic [7:0] PUSH_DATA_OUT,
  input wire logic [2:0] JUMP_COND_IN, input wire logic JUMP_INVERT_IN,
  input wire logic JUMP_TAKEN_OUT, input wire logic [7:0] FLAGS_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // only carry, zero, sign and overflow reach the jump test
  function automatic logic ev(input logic [7:0] f, input logic [2:0] c);
    logic [7:0] t;
    t = {f[7] | f[6], f[5] ^ f[4], 1'b1, f[4], f[5], f[6], f[7], 1'b0};
    return t[c];
  endfunction
  sequence acc_s;
    PSEL_IN && PENABLE_IN && !PREADY_OUT;
  endsequence
  alu_update_a: assert property (ALU_VALID_IN && !RESTORE_REQ_IN && !PSEL_IN |-> ##2
    (FLAGS_OUT & $past(ALU_MASK_IN, 2) & 8'hfc) === ($past(ALU_VALUE_IN & ALU_MASK_IN, 2) & 8'hfc))
    else $error("alu flags not applied");
  user_hold_a: assert property (!$past(SYS_RST_IN) && !USER_VALID_IN && !RESTORE_REQ_IN
    && !PSEL_IN |-> ##2 FLAGS_OUT[1:0] === $past(FLAGS_OUT[1:0])) else $error("user flags moved");
  restore_load_a: assert property (RESTORE_REQ_IN |-> ##2 FLAGS_OUT === $past(RESTORE_DATA_IN, 2))
    else $error("restore not loaded");
  save_push_a: assert property (SAVE_REQ_IN |=> PUSH_VALID_OUT && PUSH_DATA_OUT === FLAGS_OUT)
    else $error("push wrong");
  push_pulse_a: assert property (!SAVE_REQ_IN |=> !PUSH_VALID_OUT) else $error("stray push");
  jump_eval_a: assert property (!$past(SYS_RST_IN) |-> JUMP_TAKEN_OUT ===
    (ev(FLAGS_OUT, $past(JUMP_COND_IN)) ^ $past(JUMP_INVERT_IN))) else $error("jump wrong");
  apb_ready_a: assert property (acc_s |=> PREADY_OUT ##1 !PREADY_OUT) else $error("ready wrong");
  // every address off the three mapped words is refused, not only those above the last
  apb_error_a: assert property (acc_s |=> PSLVERR_OUT == ($past(PADDR_IN) != 12'h000
    && $past(PADDR_IN) != 12'h004 && $past(PADDR_IN) != 12'h008))
    else $error("slverr wrong");
endmodule
bind cpu_status_flags cpu_status_flags_asserts cpu_status_flags_asserts_inst (.*);

// [testbench/cpu_exec_model.sv]
// model: execution unit issuing flag updates and keeping the interrupt stack
// assumes the bench gives one operation at a time, never popping an empty stack
`timescale 1ns/1ps
module cpu_exec_model (
  // control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [1:0] kind_in,
  // stack
  input wire logic push_valid_in,
  input wire logic [7:0] push_data_in,
  output logic alu_valid_out = 1'b0,
  output logic user_valid_out = 1'b0,
  output logic save_out = 1'b0,
  output logic restore_out = 1'b0,
  output logic [7:0] restore_data_out = 8'h5a
);
  logic [7:0] stack[$];
  always @(posedge clk_in) begin
    alu_valid_out <= go_in && kind_in == 2'h0 && !rst_in;
    user_valid_out <= go_in && kind_in == 2'h1 && !rst_in;
    save_out <= go_in && kind_in == 2'h2 && !rst_in;
    restore_out <= go_in && kind_in == 2'h3 && !rst_in;
    restore_data_out <= ~restore_data_out;
    if (push_valid_in) stack.push_back(push_data_in);
    if (go_in && kind_in == 2'h3) restore_data_out <= stack.pop_back();
  end
endmodule

// [testbench/cpu_status_flags_tb.sv]
// bench: flags block with execution model and apb master
// assumes 50 MHz clock, synchronous active-high reset
`timescale 1ns/1ps
module cpu_status_flags_tb;
  localparam logic [7:0] CM = flags_pkg::CONDITION_MASK;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0, inv = 0, gerr;
  logic pready, perr, pv, av, uv, sv, rv, jt;
  logic [11:0] addr = 0;
  logic [31:0] wd = 0, rd, got, seed = 32'h280d, r;
  logic [7:0] mask = 0, val = 0, exp, pd, rdat, flags, lsv = 0;
  logic [2:0] cond = 0;
  logic [1:0] kind = 0;
  logic [7:0] q[$];
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  cpu_status_flags cpu_status_flags_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(addr), .PWDATA_IN(wd), .PSTRB_IN(4'hf),
    .PRDATA_OUT(rd), .PREADY_OUT(pready), .PSLVERR_OUT(perr), .ALU_VALID_IN(av),
    .ALU_MASK_IN(mask), .ALU_VALUE_IN(val), .USER_VALID_IN(uv), .USER_MASK_IN(mask[1:0]),
    .USER_VALUE_IN(val[1:0]), .SAVE_REQ_IN(sv), .RESTORE_REQ_IN(rv), .RESTORE_DATA_IN(rdat),
    .PUSH_VALID_OUT(pv), .PUSH_DATA_OUT(pd), .JUMP_COND_IN(cond), .JUMP_INVERT_IN(inv),
    .JUMP_TAKEN_OUT(jt), .FLAGS_OUT(flags));
  cpu_exec_model cpu_exec_model_inst (.clk_in(clk), .rst_in(rst), .go_in(go), .kind_in(kind),
    .push_valid_in(pv), .push_data_in(pd), .alu_valid_out(av), .user_valid_out(uv),
    .save_out(sv), .restore_out(rv), .restore_data_out(rdat));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    got = rd;
    gerr = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic op(input logic [1:0] k, input logic [7:0] m, input logic [7:0] v);
    if (k == 2'h3 && q.size() == 0) k = 2'h2;
    r = rnd();
    @(posedge clk);
    go <= 1;
    kind <= k;
    mask <= m;
    val <= v;
    cond <= r[2:0];
    inv <= r[3];
    @(posedge clk);
    go <= 0;
    repeat (3) @(posedge clk);
    case (k)
      2'h0: exp = exp & ~(m & CM) | v & m & CM;
      2'h1: exp[1:0] = exp[1:0] & ~m[1:0] | v[1:0] & m[1:0];
      2'h2: begin
        q.push_back(exp);
        lsv = exp;
      end
      default: exp = q.pop_back();
    endcase
    #1 chk("flags", {24'h0, exp}, {24'h0, flags});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    exp = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 0;
    op(2'h1, 8'h03, 8'h02);
    apb(1, flags_pkg::FLAGS_OFFSET, 32'hf2);
    exp = 8'hf2;
    apb(0, flags_pkg::FLAGS_OFFSET, 0);
    chk("flags read", 32'hf2, got);
    apb(1, flags_pkg::JUMP_TEST_OFFSET, 32'h1);
    apb(0, flags_pkg::JUMP_TEST_OFFSET, 0);
    chk("jump test", {27'h0, exp[flags_pkg::CARRY_BIT], 4'h1}, got);
    apb(0, 12'h00c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, gerr});
    chk("unmapped data", 32'h0, got);
    repeat (400) begin
      r = rnd();
      op(r[1:0], r[15:8], r[23:16]);
    end
    apb(0, flags_pkg::SAVED_OFFSET, 0);
    chk("saved read", {24'h0, lsv}, got);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    #1 chk("flags after reset", {24'h0, exp & flags_pkg::USER_MASK}, {24'h0, flags});
    give_verdict();
  end
endmodule
